// ==== core/xlate_pkg.sv ====
// Purpose: Shared constants for the address translation block
// Assumes: 32-bit virtual and physical addresses, 16-entry main buffer
// Notes:   Entry layouts match the software-visible register format
package xlate_pkg;
  localparam int unsigned ENTRIES         = 16;
  localparam logic [11:0] OFF_IRAM        = 12'h0400;
  localparam logic [11:0] OFF_ICAM        = 12'h0404;
  localparam logic [11:0] OFF_MRAM_BASE   = 12'h0800;
  localparam logic [11:0] OFF_MCAM_BASE   = 12'h0840;
  localparam logic [11:0] OFF_CTRL        = 12'h0410;
  localparam logic [11:0] OFF_DFAR        = 12'h0420;
  localparam logic [11:0] OFF_STATUS      = 12'h0424;
  localparam int unsigned RAM_PPN_LSB     = 12;
  localparam int unsigned RAM_G_BIT       = 11;
  localparam int unsigned RAM_FE_BIT      = 10;
  localparam int unsigned RAM_V_BIT       = 9;
  localparam int unsigned RAM_C_BIT       = 8;
  localparam int unsigned RAM_M_BIT       = 7;
  localparam int unsigned RAM_R_BIT       = 6;
  localparam int unsigned RAM_ACC_LSB     = 3;
  localparam int unsigned CAM_VPN_LSB     = 12;
  localparam int unsigned CAM_FI_LSB      = 10;
  localparam int unsigned CAM_G_BIT       = 9;
  localparam int unsigned CAM_FE_BIT      = 8;
  localparam int unsigned CAM_LVL_LSB     = 6;
  localparam int unsigned CTRL_EN_BIT     = 0;
  localparam int unsigned CTRL_ICD_BIT    = 1;
  localparam int unsigned CTRL_DCD_BIT    = 2;
  localparam int unsigned DFAR_LSB        = 10;
  localparam logic [2:0]  ACC_SUPER_ONLY  = 3'h7;
  localparam logic [31:0] RESET_WORD      = 32'h0000_0000;
endpackage : xlate_pkg

// ==== core/xlate_match.sv ====
// Purpose: Combinational match and address forming for one entry
// Assumes: RAM and CAM words in software layout
// Notes:   Shared by instruction buffer and every main buffer entry
`timescale 1ns/100ps
`default_nettype none
module xlate_match
  import xlate_pkg::*;
(
  input  wire logic [31:0] ram_i,
  input  wire logic [31:0] cam_i,
  input  wire logic [31:0] vaddr_i,
  output logic             hit_o,
  output logic [31:0]      paddr_o
);
  logic [2:0]  mask;
  logic [19:0] keep;
  logic        fi_ok;

  assign mask  = ram_i[2:0];
  // Masked index fields drop out of the compare
  assign keep  = {{8{~mask[0]}}, {6{~mask[1]}}, {6{~mask[2]}}};
  assign fi_ok = ~ram_i[RAM_FE_BIT]
               | (cam_i[CAM_FI_LSB +: 2] == vaddr_i[11:10]);
  assign hit_o = ram_i[RAM_V_BIT] & fi_ok
               & (((cam_i[31:12] ^ vaddr_i[31:12]) & keep) == 20'h0_0000);
  assign paddr_o = {(ram_i[31:12] & keep) | (vaddr_i[31:12] & ~keep),
                    vaddr_i[11:0]};
endmodule : xlate_match
`default_nettype wire

// ==== core/xlate_unit.sv ====
// Purpose: Instruction buffer plus 16-entry main translation buffer
// Assumes: Pipeline holds fetch while hold_o is high
// Notes:   Context compare is outside this block; plain register port
// What this block does
// - RAM entry bits 31-12 hold page number, low part replaced per mask
// - RAM bits 11 and 10 copy global and fragment-enable flags
// - Fragment enable set: fragment index must equal address bits 11-10
// - Fragment enable clear: fragment index ignored, whole page protected
// - Bit 8 cacheable flag delivered with physical address on match
// - Bit 7 modified flag set by write to mapped page
// - Bit 6 referenced flag set on every access through entry
// - Access level bits 5-3 checked every lookup; violation traps
// - Level 7 denies user, allows supervisor everything
// - Bits 2-0 hold decoded page-size mask bits
// - Instruction buffer RAM at 0x400, CAM at 0x404
// - Instruction buffer decides fetch permission; violation is instruction fault
// - Instruction buffer miss holds pipeline, next cycle uses main buffer
// - Main buffer hit refills instruction buffer, retry succeeds, two cycles
// - Miss in both buffers flags instruction fault
// - Data addresses compared against all entries; output address, flags
// - Data miss or protection violation raises data fault
// - All faults taken at end of memory stage
// - Cache disabled with translation on adds one cycle to data accesses
// - Trap squashes stages, writes virtual program counter instead
// - Data fault captures virtual data address
// - Emulation port execution bypasses translation
// - Access codes 0-6 grant documented permission sets
// - Mask bits replace low 6, 12 or all page bits
// - Data fault address read-only, upper 22 bits, clear on read
`timescale 1ns/100ps
`default_nettype none
module xlate_unit
  import xlate_pkg::*;
#(
  parameter int unsigned N_ENTRIES = xlate_pkg::ENTRIES
)(
  input  wire logic        core_clk_i,
  input  wire logic        rst_b_i,
  input  wire logic [11:0] reg_addr_i,
  input  wire logic [31:0] reg_wdata_i,
  input  wire logic        reg_wr_i,
  input  wire logic        reg_rd_i,
  output logic [31:0]      reg_rdata_o,
  input  wire logic [31:0] fetch_vaddr_i,
  input  wire logic        fetch_req_i,
  input  wire logic        fetch_super_i,
  output logic [31:0]      fetch_paddr_o,
  output logic             fetch_cacheable_o,
  output logic             fetch_valid_o,
  output logic             hold_o,
  input  wire logic [31:0] data_vaddr_i,
  input  wire logic        data_req_i,
  input  wire logic        data_write_i,
  input  wire logic        data_super_i,
  output logic [31:0]      data_paddr_o,
  output logic             data_cacheable_o,
  output logic [2:0]       data_access_level_o,
  output logic             data_valid_o,
  input  wire logic        emulation_port_i,
  input  wire logic        mem_stage_end_i,
  input  wire logic [31:0] mem_stage_pc_i,
  output logic             trap_o,
  output logic             trap_instr_o,
  output logic             squash_o,
  output logic             pc_writeback_o,
  output logic [31:0]      pc_writeback_data_o
);
  import xlate_pkg::*;

  typedef enum logic [2:0] {
    ST_RUN    = 3'b001,
    ST_REFILL = 3'b010,
    ST_RETRY  = 3'b100
  } fsm_t;

  fsm_t        state;
  fsm_t        next_state;
  logic [31:0] mram [N_ENTRIES];
  logic [31:0] mcam [N_ENTRIES];
  logic [31:0] iram;
  logic [31:0] icam;
  logic [31:0] ctrl;
  logic [21:0] dfar;
  logic        ifault_pend;
  logic        dfault_pend;
  logic        dwait;
  logic        fetch_faulted;

  // Access check: rd=read, wr=write, ex=execute
  function automatic logic acc_ok(input logic [2:0] acc, input logic sup,
                                  input logic wr, input logic ex);
    logic rd;
    logic w;
    logic x;
    rd = 1'b0;
    w  = 1'b0;
    x  = 1'b0;
    unique case (acc)
      3'd0: rd = 1'b1;
      3'd1: begin rd = 1'b1; w = 1'b1; end
      3'd2: begin rd = 1'b1; x = 1'b1; end
      3'd3: begin rd = 1'b1; w = 1'b1; x = 1'b1; end
      3'd4: x = 1'b1;
      3'd5: begin rd = 1'b1; w = sup; end
      3'd6: begin rd = sup; x = sup; end
      3'd7: begin rd = sup; w = sup; x = sup; end
    endcase
    return ex ? x : (wr ? w : rd);
  endfunction : acc_ok

  logic        xlate_on;
  logic        i_hit;
  logic [31:0] i_pa;
  logic [N_ENTRIES-1:0] m_hit;
  logic [31:0] m_pa [N_ENTRIES];
  logic [31:0] lookup_va;
  logic        m_any;
  logic [$clog2(N_ENTRIES)-1:0] m_idx;
  logic        i_prot_ok;
  logic        d_prot_ok;
  logic        refill;
  logic        cache_off;

  assign xlate_on  = ctrl[CTRL_EN_BIT] & ~emulation_port_i;
  assign cache_off = ctrl[CTRL_ICD_BIT] | ctrl[CTRL_DCD_BIT];
  assign refill    = (state == ST_REFILL);
  // Refill cycle borrows the main buffer from the data side
  assign lookup_va = refill ? fetch_vaddr_i : data_vaddr_i;

  xlate_match u_imatch (
    .ram_i   (iram),
    .cam_i   (icam),
    .vaddr_i (fetch_vaddr_i),
    .hit_o   (i_hit),
    .paddr_o (i_pa)
  );

  genvar g;
  generate
    for (g = 0; g < N_ENTRIES; g++) begin : g_ent
      xlate_match u_match (
        .ram_i   (mram[g]),
        .cam_i   (mcam[g]),
        .vaddr_i (lookup_va),
        .hit_o   (m_hit[g]),
        .paddr_o (m_pa[g])
      );
    end
  endgenerate

  always_comb begin
    m_idx = '0;
    for (int k = N_ENTRIES - 1; k >= 0; k--) begin
      if (m_hit[k]) begin
        m_idx = k[$clog2(N_ENTRIES)-1:0];
      end
    end
  end
  assign m_any = |m_hit;

  assign i_prot_ok = acc_ok(iram[RAM_ACC_LSB +: 3], fetch_super_i, 1'b0, 1'b1);
  assign d_prot_ok = acc_ok(mram[m_idx][RAM_ACC_LSB +: 3], data_super_i,
                            data_write_i, 1'b0);

  // Fetch sequencing
  always_comb begin
    next_state = state;
    unique case (state)
      ST_RUN: begin
        if (fetch_req_i && xlate_on && !i_hit && !fetch_faulted) begin
          next_state = ST_REFILL;
        end
      end
      ST_REFILL: next_state = m_any ? ST_RETRY : ST_RUN;
      ST_RETRY:  next_state = ST_RUN;
    endcase
  end

  always_ff @(posedge core_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      state <= ST_RUN;
    end else begin
      state <= next_state;
    end
  end

  assign hold_o = xlate_on & fetch_req_i & ((state == ST_RUN) ? ~i_hit & ~fetch_faulted
                : (state == ST_REFILL));

  // A failed refill lets the faulting fetch move on instead of refilling forever.
  // Cleared only when the request drops, so a new address must not follow back to back.
  always_ff @(posedge core_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      fetch_faulted <= 1'b0;
    end else begin
      fetch_faulted <= fetch_req_i & (fetch_faulted | (refill & ~m_any));
    end
  end

  // Extra cycle before driving data address when a cache is off
  always_ff @(posedge core_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      dwait <= 1'b0;
    end else begin
      dwait <= data_req_i & xlate_on & cache_off & ~dwait & ~refill;
    end
  end

  // Fetch outputs
  always_ff @(posedge core_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      fetch_paddr_o     <= RESET_WORD;
      fetch_cacheable_o <= 1'b0;
      fetch_valid_o     <= 1'b0;
    end else begin
      fetch_valid_o <= 1'b0;
      if (fetch_req_i && !xlate_on) begin
        fetch_paddr_o     <= fetch_vaddr_i;
        fetch_cacheable_o <= 1'b1;
        fetch_valid_o     <= 1'b1;
      end else if (fetch_req_i && state != ST_REFILL && i_hit && i_prot_ok) begin
        fetch_paddr_o     <= i_pa;
        fetch_cacheable_o <= iram[RAM_C_BIT];
        fetch_valid_o     <= 1'b1;
      end
    end
  end

  logic d_go;
  assign d_go = data_req_i & xlate_on & ~refill & ~(cache_off & ~dwait);

  // Data outputs
  always_ff @(posedge core_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      data_paddr_o        <= RESET_WORD;
      data_cacheable_o    <= 1'b0;
      data_access_level_o <= 3'h0;
      data_valid_o        <= 1'b0;
    end else begin
      data_valid_o <= 1'b0;
      if (data_req_i && !xlate_on) begin
        data_paddr_o <= data_vaddr_i;
        data_cacheable_o <= 1'b1;
        data_valid_o <= 1'b1;
      end else if (d_go && m_any && d_prot_ok) begin
        data_paddr_o        <= m_pa[m_idx];
        data_cacheable_o    <= mram[m_idx][RAM_C_BIT];
        data_access_level_o <= mram[m_idx][RAM_ACC_LSB +: 3];
        data_valid_o        <= 1'b1;
      end
    end
  end

  // Faults are held until the faulting instruction leaves memory stage
  logic i_fault_now;
  logic d_fault_now;
  assign i_fault_now = fetch_req_i & xlate_on & ((state != ST_REFILL & i_hit & ~i_prot_ok)
                     | (refill & ~m_any));
  assign d_fault_now = d_go & ~(m_any & d_prot_ok);

  always_ff @(posedge core_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      ifault_pend <= 1'b0;
      dfault_pend <= 1'b0;
    end else begin
      ifault_pend <= i_fault_now | (ifault_pend & ~mem_stage_end_i);
      dfault_pend <= (d_fault_now & ~mem_stage_end_i) | (dfault_pend & ~mem_stage_end_i);
    end
  end

  logic take_trap;
  assign take_trap = mem_stage_end_i & (ifault_pend | dfault_pend | d_fault_now);

  always_ff @(posedge core_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      trap_o              <= 1'b0;
      trap_instr_o        <= 1'b0;
      squash_o            <= 1'b0;
      pc_writeback_o      <= 1'b0;
      pc_writeback_data_o <= RESET_WORD;
    end else begin
      trap_o         <= take_trap;
      trap_instr_o   <= take_trap & ifault_pend;
      squash_o       <= take_trap;
      pc_writeback_o <= take_trap;
      if (take_trap) begin
        pc_writeback_data_o <= mem_stage_pc_i;
      end
    end
  end

  // Register decode helpers
  function automatic logic hit_at(input logic [11:0] a, input logic [11:0] off);
    return a == off;
  endfunction : hit_at

  logic        mram_sel;
  logic        mcam_sel;
  logic [3:0]  ridx;
  assign mram_sel = reg_addr_i[11:6] == OFF_MRAM_BASE[11:6];
  assign mcam_sel = reg_addr_i[11:6] == OFF_MCAM_BASE[11:6];
  assign ridx     = reg_addr_i[5:2];

  // Instruction buffer storage and refill
  always_ff @(posedge core_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      iram <= RESET_WORD;
      icam <= RESET_WORD;
    end else if (refill && m_any) begin
      iram <= mram[m_idx] | (32'h0000_0001 << RAM_R_BIT);
      icam <= mcam[m_idx];
    end else if (reg_wr_i && hit_at(reg_addr_i, OFF_IRAM)) begin
      iram <= reg_wdata_i;
    end else if (reg_wr_i && hit_at(reg_addr_i, OFF_ICAM)) begin
      icam <= reg_wdata_i;
    end
  end

  // Main buffer entries; status bits set by hardware win over writes
  generate
    for (g = 0; g < N_ENTRIES; g++) begin : g_store
      always_ff @(posedge core_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
          mram[g] <= RESET_WORD;
          mcam[g] <= RESET_WORD;
        end else begin
          if (reg_wr_i && mcam_sel && ridx == g) begin
            mcam[g] <= reg_wdata_i;
          end
          if (reg_wr_i && mram_sel && ridx == g) begin
            mram[g] <= {reg_wdata_i[31:12],
                        mcam[g][CAM_G_BIT], mcam[g][CAM_FE_BIT],
                        reg_wdata_i[9:3],
                        reg_wdata_i[2:0]};
          end
          if (m_hit[g] && m_idx == g && (refill || d_go)) begin
            mram[g][RAM_R_BIT] <= 1'b1;
            if (d_go && data_write_i && d_prot_ok) begin
              mram[g][RAM_M_BIT] <= 1'b1;
            end
          end
        end
      end
    end
  endgenerate

  // Control register and fault address
  always_ff @(posedge core_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      ctrl <= RESET_WORD;
    end else if (reg_wr_i && hit_at(reg_addr_i, OFF_CTRL)) begin
      ctrl <= {29'h0, reg_wdata_i[2:0]};
    end
  end

  always_ff @(posedge core_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      dfar <= 22'h00_0000;
    end else if (d_fault_now) begin
      dfar <= data_vaddr_i[31:DFAR_LSB];
    end else if (reg_rd_i && hit_at(reg_addr_i, OFF_DFAR)) begin
      dfar <= 22'h00_0000;
    end
  end

  always_ff @(posedge core_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      reg_rdata_o <= RESET_WORD;
    end else if (reg_rd_i) begin
      if (mram_sel) begin
        reg_rdata_o <= mram[ridx];
      end else if (mcam_sel) begin
        reg_rdata_o <= mcam[ridx];
      end else if (hit_at(reg_addr_i, OFF_IRAM)) begin
        reg_rdata_o <= iram;
      end else if (hit_at(reg_addr_i, OFF_ICAM)) begin
        reg_rdata_o <= icam;
      end else if (hit_at(reg_addr_i, OFF_CTRL)) begin
        reg_rdata_o <= ctrl;
      end else if (hit_at(reg_addr_i, OFF_DFAR)) begin
        reg_rdata_o <= {dfar, 10'h000};
      end else if (hit_at(reg_addr_i, OFF_STATUS)) begin
        reg_rdata_o <= {27'h000_0000, ifault_pend, dfault_pend, state};
      end else begin
        reg_rdata_o <= RESET_WORD;
      end
    end
  end

  chk_refill_follows_miss: assert property (@(posedge core_clk_i) disable iff (!rst_b_i)
    state == ST_RUN && fetch_req_i && xlate_on && !i_hit && !fetch_faulted
    |=> state == ST_REFILL)
    else $error("miss did not start refill");
  chk_retry_hits: assert property (@(posedge core_clk_i) disable iff (!rst_b_i)
    refill && m_any && fetch_req_i |=> i_hit)
    else $error("retry after refill missed");
  chk_double_miss_fault: assert property (@(posedge core_clk_i) disable iff (!rst_b_i)
    refill && !m_any && fetch_req_i && xlate_on |=> ifault_pend)
    else $error("double miss without fault");
  chk_dfar_capture: assert property (@(posedge core_clk_i) disable iff (!rst_b_i)
    d_fault_now |=> dfar == $past(data_vaddr_i[31:10]))
    else $error("fault address not captured");
  chk_trap_pc_write: assert property (@(posedge core_clk_i) disable iff (!rst_b_i)
    take_trap |=> squash_o && pc_writeback_data_o == $past(mem_stage_pc_i))
    else $error("trap without pc writeback");
  chk_bypass_emul: assert property (@(posedge core_clk_i) disable iff (!rst_b_i)
    data_req_i && emulation_port_i |=> data_valid_o && data_paddr_o == $past(data_vaddr_i))
    else $error("emulation access translated");
  chk_hold_in_refill: assert property (@(posedge core_clk_i) disable iff (!rst_b_i)
    refill && fetch_req_i |-> hold_o && !fetch_valid_o)
    else $error("no hold during refill");
  chk_level7_user: assert property (@(posedge core_clk_i) disable iff (!rst_b_i)
    d_go && m_any && !data_super_i && mram[m_idx][5:3] == 3'h7 |-> d_fault_now)
    else $error("user allowed on level 7");
  cov_refill: cover property (@(posedge core_clk_i) state == ST_REFILL ##1 state == ST_RETRY);
  cov_dtrap: cover property (@(posedge core_clk_i) take_trap && !ifault_pend);
  cov_itrap: cover property (@(posedge core_clk_i) take_trap && ifault_pend);
endmodule : xlate_unit
`default_nettype wire

// ==== testbench/pipe_model.sv ====
// Purpose: Fetch stage model issuing one instruction fetch at a time
// Assumes: hold_i is settled by mid-cycle, before the edge that samples it
// Notes:   Released address lines show the inverse so stale values never match
`timescale 1ns/100ps
`default_nettype none
module pipe_model (
  input  wire logic        core_clk_i,
  input  wire logic        hold_i,
  input  wire logic        valid_i,
  input  wire logic [31:0] paddr_i,
  output var logic         fetch_req_o,
  output var logic [31:0]  fetch_vaddr_o,
  output var logic         fetch_super_o
);
  initial begin
    fetch_req_o = 1'b0;
    fetch_vaddr_o = 32'h0000_0000;
    fetch_super_o = 1'b0;
  end
  // Latency counts edges from launch to the first cycle that shows valid
  task automatic fetch(input logic [31:0] a, input logic sup, output int lat,
                       output logic [31:0] pa);
    logic h;
    lat = 0;
    pa = 32'h0000_0000;
    @(posedge core_clk_i);
    fetch_req_o <= 1'b1;
    fetch_vaddr_o <= a;
    fetch_super_o <= sup;
    for (int i = 1; i < 8 && lat == 0; i++) begin
      @(negedge core_clk_i);
      h = hold_i;
      if (valid_i === 1'b1) begin
        lat = i;
        pa = paddr_i;
      end
      @(posedge core_clk_i);
      if (!h) begin
        fetch_req_o <= 1'b0;  // Request and address kept while hold is up
        fetch_vaddr_o <= ~a;
      end
    end
  endtask : fetch
endmodule : pipe_model
`default_nettype wire

// ==== testbench/xlate_unit_tb.sv ====
// Purpose: Self-checking bench for the translation unit
// Assumes: Entry 0 maps a 4-Kbyte page, entry 1 is reprogrammed per level
// Notes:   Fault traps are only expected after the memory-stage end pulse
`timescale 1ns/100ps
`default_nettype none
module xlate_unit_tb;
  import xlate_pkg::*;
  logic        core_clk_i = 1'b0, rst_b_i = 1'b0, reg_wr_i = 1'b0, reg_rd_i = 1'b0;
  logic        data_req_i = 1'b0, data_write_i = 1'b0, data_super_i = 1'b0;
  logic        emulation_port_i = 1'b0, mem_stage_end_i = 1'b0;
  logic [11:0] reg_addr_i = 12'h0000;
  logic [31:0] reg_wdata_i = 32'h0000_0000, data_vaddr_i = 32'h0000_0000;
  logic [31:0] mem_stage_pc_i = 32'h0000_0000, fetch_vaddr_i;
  logic [31:0] reg_rdata_o, fetch_paddr_o, data_paddr_o, pc_writeback_data_o;
  logic [2:0]  data_access_level_o;
  logic        fetch_cacheable_o, fetch_valid_o, hold_o, data_cacheable_o, data_valid_o;
  logic        trap_o, trap_instr_o, squash_o, pc_writeback_o, fetch_req_i, fetch_super_i;
  int          bad_count = 0, comparisons = 0, cycles = 0;

  always #4 core_clk_i = ~core_clk_i;

  xlate_unit dut_u (.*);
  pipe_model pm (.core_clk_i(core_clk_i), .hold_i(hold_o), .valid_i(fetch_valid_o),
                 .paddr_i(fetch_paddr_o), .fetch_req_o(fetch_req_i),
                 .fetch_vaddr_o(fetch_vaddr_i), .fetch_super_o(fetch_super_i));

  task automatic complete_run();
    if (bad_count == 0 && comparisons > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask : complete_run

  // Run is a few hundred cycles; the ceiling only catches a hang
  always @(posedge core_clk_i) begin
    cycles <= cycles + 1;
    if (cycles == 5000) begin
      bad_count = bad_count + 1;
      complete_run();
    end
  end

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    comparisons = comparisons + 1;
    if (seen !== exp) begin
      bad_count = bad_count + 1;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check

  task automatic reg_wr(input logic [11:0] a, input logic [31:0] d);
    @(posedge core_clk_i);
    reg_addr_i <= a;
    reg_wdata_i <= d;
    reg_wr_i <= 1'b1;
    @(posedge core_clk_i);
    reg_wr_i <= 1'b0;
  endtask : reg_wr

  task automatic rd_chk(input logic [11:0] a, input logic [31:0] exp);
    @(posedge core_clk_i);
    reg_addr_i <= a;
    reg_rd_i <= 1'b1;
    @(posedge core_clk_i);
    reg_rd_i <= 1'b0;
    #1 check(reg_rdata_o, exp);
  endtask : rd_chk

  // Holds the request for n edges; returns the first cycle showing valid, zero when none came
  task automatic data_op(input logic [31:0] va, input logic wr, input logic sup,
                         input int n, output int lat);
    @(posedge core_clk_i);
    data_vaddr_i <= va;
    data_write_i <= wr;
    data_super_i <= sup;
    data_req_i <= 1'b1;
    lat = 0;
    for (int i = 1; i < 5; i++) begin
      @(posedge core_clk_i);
      if (i == n) begin
        data_req_i <= 1'b0;
        data_vaddr_i <= ~va;
      end
      @(negedge core_clk_i);
      if (lat == 0 && data_valid_o === 1'b1) lat = i;
    end
  endtask : data_op

  task automatic end_mem(input logic [31:0] pc);
    @(posedge core_clk_i);
    mem_stage_end_i <= 1'b1;
    mem_stage_pc_i <= pc;
    @(posedge core_clk_i);
    mem_stage_end_i <= 1'b0;
    #1;
  endtask : end_mem

  task automatic t_regs();
    for (int i = 0; i < ENTRIES; i++) begin
      reg_wr(OFF_MRAM_BASE + 12'(4 * i), 32'h0000_0000);
    end
    reg_wr(OFF_ICAM, 32'hABCD_E000);
    reg_wr(OFF_IRAM, 32'h5555_5000);
    rd_chk(OFF_ICAM, 32'hABCD_E000);
    rd_chk(OFF_IRAM, 32'h5555_5000);
    rd_chk(12'h0FFC, 32'h0000_0000);
    reg_wr(OFF_MCAM_BASE, 32'h0001_02C0);
    reg_wr(OFF_MRAM_BASE, 32'h1234_5318);
    rd_chk(OFF_MRAM_BASE, 32'h1234_5B18);
    reg_wr(OFF_MCAM_BASE + 12'h0004, 32'h0002_02C0);
    reg_wr(OFF_CTRL, 32'h0000_0001);
  endtask : t_regs

  task automatic t_fetch();
    int l1, l2;
    logic [31:0] pa;
    pm.fetch(32'h0001_0ABC, 1'b1, l1, pa);
    check(pa, 32'h1234_5ABC);
    pm.fetch(32'h0001_0FF0, 1'b1, l2, pa);
    check(pa, 32'h1234_5FF0);
    check(32'(l1 - l2), 32'h0000_0002);
    check(32'(fetch_cacheable_o), 32'h0000_0001);
  endtask : t_fetch

  task automatic t_data();
    int l1, l2;
    data_op(32'h0001_0444, 1'b0, 1'b0, 1, l1);
    check(data_paddr_o, 32'h1234_5444);
    check(32'(data_cacheable_o), 32'h0000_0001);
    check(32'(data_access_level_o), 32'h0000_0003);
    rd_chk(OFF_MRAM_BASE, 32'h1234_5B58);
    data_op(32'h0001_0448, 1'b1, 1'b0, 1, l1);
    check(32'(l1), 32'h0000_0001);
    rd_chk(OFF_MRAM_BASE, 32'h1234_5BD8);
    reg_wr(OFF_CTRL, 32'h0000_0005);
    data_op(32'h0001_0444, 1'b0, 1'b0, 2, l2);
    check(32'(l2 - l1), 32'h0000_0001);
    reg_wr(OFF_CTRL, 32'h0000_0001);
  endtask : t_data

  // Every level code against user and supervisor writes
  task automatic t_levels();
    int l;
    logic [7:0] ok;
    for (int s = 0; s < 2; s++) begin
      ok = (s == 0) ? 8'h0A : 8'hAA;
      for (int c = 0; c < 8; c++) begin
        reg_wr(OFF_MRAM_BASE + 12'h0004, 32'h2222_2300 | (32'(c) << 3));
        data_op(32'h0002_0010, 1'b1, s[0], 1, l);
        end_mem(32'h0000_1000);
        check(32'(trap_o), 32'(!ok[c]));
      end
    end
  endtask : t_levels

  task automatic t_faults();
    int l;
    logic [31:0] pa;
    data_op(32'h0003_0ABC, 1'b0, 1'b1, 1, l);
    check(32'(trap_o), 32'h0000_0000);
    end_mem(32'h0000_2040);
    check(32'(trap_o & squash_o & pc_writeback_o), 32'h0000_0001);
    check(pc_writeback_data_o, 32'h0000_2040);
    rd_chk(OFF_DFAR, 32'h0003_0800);
    rd_chk(OFF_DFAR, 32'h0000_0000);
    pm.fetch(32'h0004_0000, 1'b1, l, pa);
    end_mem(32'h0000_3000);
    check(32'(trap_instr_o), 32'h0000_0001);
    pm.fetch(32'h0002_0100, 1'b0, l, pa);
    end_mem(32'h0000_3004);
    check(32'(trap_instr_o), 32'h0000_0001);
    @(posedge core_clk_i);
    emulation_port_i <= 1'b1;
    data_op(32'h0003_0ABC, 1'b0, 1'b0, 1, l);
    check(data_paddr_o, 32'h0003_0ABC);
  endtask : t_faults

  initial begin
    repeat (5) @(posedge core_clk_i);
    rst_b_i <= 1'b1;
    t_regs();
    t_fetch();
    t_data();
    t_levels();
    t_faults();
    complete_run();
  end
endmodule : xlate_unit_tb
`default_nettype wire
